// ===== common/line_error_pkg.sv
// Behaviour
// - AMI: two successive pulses of equal polarity give a bipolar violation.
// - HDB3/B8ZS: same-polarity pulse outside a valid substitution gives a code violation.
// - AMI excess zeros: more than 15 (ANSI) or 80 (FCC) zeros.
// - HDB3 more than 3 zeros, B8ZS more than 7, whatever the standard.
// - Error select picks one error type; value 11 counts violations and excess zeros.
// - Error select 00 counts received pseudo-random pattern logic errors.
// - 16-bit internal counter; each detected error sets a status flag, interrupts unless masked.
// - Single-rail mode: violation pin high one receive bit period per violation.
// - Report mode bit: 1 automatic, 0 manual; counting starts once mode is written.
// - Automatic: each one-second expiry copies count to results, clears, restarts.
// - Errors arriving during a copy go into the next interval.
// - Timer expiry sets timer flag; interrupt when timer mask is 0.
// - Reading the status register clears the timer flag.
// - Counter overflow sets overflow flag; interrupt unless overflow mask set.
// - Manual: rising transfer-request bit copies count to results then clears counter.
// - Rising violation-insert bit inverts second of three consecutive transmit ones.
// - Rising logic-error-insert bit flips one bit of the transmitted test pattern.
package line_error_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam int COUNT_W = 16;

    localparam logic [7:0] OFS_MAINT_CONTROL = 8'h10;
    localparam logic [7:0] OFS_INT_MASK = 8'h12;
    localparam logic [7:0] OFS_INT_STATUS = 8'h17;
    localparam logic [7:0] OFS_COUNT_LOW = 8'h18;
    localparam logic [7:0] OFS_COUNT_HIGH = 8'h19;

    // error_maintenance_control fields
    localparam int BIT_REPORT_MODE = 0;
    localparam int BIT_TRANSFER_REQUEST = 1;
    localparam int BIT_SEL_LO = 2;
    localparam int BIT_SEL_HI = 3;
    localparam int BIT_ZERO_STANDARD = 4;
    localparam int BIT_VIOLATION_INSERT = 5;
    localparam int BIT_LOGIC_ERROR_INSERT = 6;

    // interrupt status / mask fields
    localparam int BIT_PATTERN_ERROR = 0;
    localparam int BIT_VIOLATION = 1;
    localparam int BIT_EXCESS_ZERO = 2;
    localparam int BIT_TIMER = 3;
    localparam int BIT_OVERFLOW = 4;
    localparam int FLAG_COUNT = 5;

    localparam logic [7:0] RESET_CONTROL = 8'h00;
    localparam logic [7:0] RESET_MASK = 8'hff;
    localparam logic [7:0] RESET_STATUS = 8'h00;

    localparam logic [1:0] SEL_PATTERN = 2'h0;
    localparam logic [1:0] SEL_VIOLATION = 2'h1;
    localparam logic [1:0] SEL_EXCESS_ZERO = 2'h2;
    localparam logic [1:0] SEL_BOTH = 2'h3;

    localparam int ZERO_LIMIT_AMI_ANSI = 15;
    localparam int ZERO_LIMIT_AMI_FCC = 80;
    localparam int ZERO_LIMIT_HDB3 = 3;
    localparam int ZERO_LIMIT_B8ZS = 7;
    localparam int ZERO_RUN_W = 7;

    localparam int HDB3_SUB_ZEROS = 3;
    localparam int HDB3_SUB_ZEROS_B = 2;
    localparam int B8ZS_FIRST_ZEROS = 3;
    localparam int B8ZS_SECOND_ZEROS = 1;
    localparam int B8ZS_SECOND_SPACING = 3;

    localparam longint TIMER_PERIOD_MS = 1000;
    localparam longint CLK_PERIOD_PS = 5000;
    localparam longint TIMER_CYCLES = (TIMER_PERIOD_MS * 64'd1000000000) / CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        CODING_AMI,
        CODING_HDB3,
        CODING_B8ZS
    } coding_t;

    typedef struct packed {
        logic bit_en;
        logic pos;
        logic neg;
    } rail_pair_t;

    typedef struct packed {
        logic bit_en;
        logic active;
        logic data;
    } pattern_bit_t;

endpackage

// ===== core/line_error_counter.sv
`timescale 1ns/1ps
`default_nettype none
module line_error_counter #(
    parameter longint TIMER_CYCLES = line_error_pkg::TIMER_CYCLES,
    parameter int TIMER_W = 28
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [1:0] coding_mode,
    input wire logic single_rail,
    input wire line_error_pkg::rail_pair_t rx_line,
    input wire logic pattern_error,
    input wire line_error_pkg::rail_pair_t tx_line,
    output line_error_pkg::rail_pair_t tx_line_out,
    input wire line_error_pkg::pattern_bit_t tx_pattern,
    output logic tx_pattern_out,
    output logic violation_output_pin,
    output logic interrupt_request
);

    if (TIMER_CYCLES < 2 || TIMER_CYCLES >= (64'd1 << TIMER_W)) begin : g_bad_timer
        $error("timer length does not fit the timer width");
    end

    localparam logic [TIMER_W-1:0] TIMER_LAST = TIMER_W'(TIMER_CYCLES - 1);

    function automatic logic [6:0] zero_limit(input logic [1:0] mode, input logic fcc);
        if (mode == line_error_pkg::CODING_HDB3) begin
            zero_limit = 7'(line_error_pkg::ZERO_LIMIT_HDB3);
        end else if (mode == line_error_pkg::CODING_B8ZS) begin
            zero_limit = 7'(line_error_pkg::ZERO_LIMIT_B8ZS);
        end else if (fcc) begin
            zero_limit = 7'(line_error_pkg::ZERO_LIMIT_AMI_FCC);
        end else begin
            zero_limit = 7'(line_error_pkg::ZERO_LIMIT_AMI_ANSI);
        end
    endfunction

    logic [7:0] control_reg;
    logic [7:0] control_prev_reg;
    logic [7:0] mask_reg;
    logic [7:0] status_reg;
    logic [15:0] count_reg;
    logic [15:0] result_reg;
    logic [TIMER_W-1:0] timer_reg;
    logic mode_written_reg;

    // ---------------- register access ----------------
    logic write_control;
    logic read_status;
    assign write_control = reg_wr && reg_addr == line_error_pkg::OFS_MAINT_CONTROL;
    assign read_status = reg_rd && reg_addr == line_error_pkg::OFS_INT_STATUS;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_reg <= line_error_pkg::RESET_CONTROL;
        end else if (write_control) begin
            control_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mask_reg <= line_error_pkg::RESET_MASK;
        end else if (reg_wr && reg_addr == line_error_pkg::OFS_INT_MASK) begin
            mask_reg <= reg_wdata;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            control_prev_reg <= line_error_pkg::RESET_CONTROL;
        end else begin
            control_prev_reg <= control_reg;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                line_error_pkg::OFS_MAINT_CONTROL: reg_rdata <= control_reg;
                line_error_pkg::OFS_INT_MASK: reg_rdata <= mask_reg;
                line_error_pkg::OFS_INT_STATUS: reg_rdata <= status_reg;
                line_error_pkg::OFS_COUNT_LOW: reg_rdata <= result_reg[7:0];
                line_error_pkg::OFS_COUNT_HIGH: reg_rdata <= result_reg[15:8];
                default: reg_rdata <= 8'h00;
            endcase
        end
    end

    logic [1:0] error_select;
    logic auto_mode;
    logic fcc_standard;
    logic transfer_rise;
    logic violation_insert_rise;
    logic logic_error_insert_rise;
    assign error_select = control_reg[line_error_pkg::BIT_SEL_HI:line_error_pkg::BIT_SEL_LO];
    assign auto_mode = control_reg[line_error_pkg::BIT_REPORT_MODE];
    assign fcc_standard = control_reg[line_error_pkg::BIT_ZERO_STANDARD];
    assign transfer_rise = control_reg[line_error_pkg::BIT_TRANSFER_REQUEST]
        && !control_prev_reg[line_error_pkg::BIT_TRANSFER_REQUEST];
    assign violation_insert_rise = control_reg[line_error_pkg::BIT_VIOLATION_INSERT]
        && !control_prev_reg[line_error_pkg::BIT_VIOLATION_INSERT];
    assign logic_error_insert_rise = control_reg[line_error_pkg::BIT_LOGIC_ERROR_INSERT]
        && !control_prev_reg[line_error_pkg::BIT_LOGIC_ERROR_INSERT];

    // ---------------- receive line code checking ----------------
    logic pulse;
    logic last_pol_reg;
    logic have_pulse_reg;
    logic last_viol_pol_reg;
    logic [2:0] since_viol_reg;
    logic [6:0] zero_run_reg;
    logic raw_violation;
    logic sub_valid;
    logic bipolar_violation;
    logic code_violation;
    logic excess_zero_error;
    logic line_violation;

    assign pulse = rx_line.bit_en && (rx_line.pos ^ rx_line.neg);
    assign raw_violation = pulse && have_pulse_reg && (rx_line.pos == last_pol_reg);

    always_comb begin
        sub_valid = 1'b0;
        if (coding_mode == line_error_pkg::CODING_HDB3) begin
            // 000V or B00V, successive substitutions alternate polarity
            sub_valid = (zero_run_reg == 7'(line_error_pkg::HDB3_SUB_ZEROS)
                || zero_run_reg == 7'(line_error_pkg::HDB3_SUB_ZEROS_B))
                && rx_line.pos != last_viol_pol_reg;
        end else if (coding_mode == line_error_pkg::CODING_B8ZS) begin
            // 000VB0VB: first V after three zeros, second one V B 0 later
            sub_valid = zero_run_reg == 7'(line_error_pkg::B8ZS_FIRST_ZEROS)
                || (zero_run_reg == 7'(line_error_pkg::B8ZS_SECOND_ZEROS)
                && since_viol_reg == 3'(line_error_pkg::B8ZS_SECOND_SPACING));
        end
    end

    assign bipolar_violation = raw_violation && coding_mode == line_error_pkg::CODING_AMI;
    assign code_violation = raw_violation && coding_mode != line_error_pkg::CODING_AMI && !sub_valid;
    assign line_violation = bipolar_violation || code_violation;
    // zero run passes the coding limit
    assign excess_zero_error = rx_line.bit_en && !pulse
        && zero_run_reg == zero_limit(coding_mode, fcc_standard);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_pol_reg <= 1'b0;
            have_pulse_reg <= 1'b0;
        end else if (pulse) begin
            last_pol_reg <= rx_line.pos;
            have_pulse_reg <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_viol_pol_reg <= 1'b0;
            since_viol_reg <= 3'h7;
        end else if (rx_line.bit_en) begin
            if (raw_violation) begin
                last_viol_pol_reg <= rx_line.pos;
                since_viol_reg <= 3'h1;
            end else if (since_viol_reg != 3'h7) begin
                since_viol_reg <= since_viol_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            zero_run_reg <= 7'h00;
        end else if (rx_line.bit_en) begin
            if (pulse) begin
                zero_run_reg <= 7'h00;
            end else if (zero_run_reg != 7'h7f) begin
                zero_run_reg <= zero_run_reg + 7'h01;
            end
        end
    end

    // violation pin stands for one receive bit period
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            violation_output_pin <= 1'b0;
        end else if (rx_line.bit_en) begin
            violation_output_pin <= single_rail && line_violation;
        end
    end

    // ---------------- error selection and counting ----------------
    logic [1:0] increment;
    always_comb begin
        unique case (error_select)
            line_error_pkg::SEL_PATTERN: increment = {1'b0, pattern_error};
            line_error_pkg::SEL_VIOLATION: increment = {1'b0, line_violation};
            line_error_pkg::SEL_EXCESS_ZERO: increment = {1'b0, excess_zero_error};
            line_error_pkg::SEL_BOTH: increment = {1'b0, line_violation} + {1'b0, excess_zero_error};
        endcase
    end

    // counting begins once the mode bit has been written
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_written_reg <= 1'b0;
        end else if (write_control) begin
            mode_written_reg <= 1'b1;
        end
    end

    logic mode_changed;
    logic timer_expire;
    logic transfer;
    assign mode_changed = write_control
        && reg_wdata[line_error_pkg::BIT_REPORT_MODE] != auto_mode;
    assign timer_expire = mode_written_reg && auto_mode && timer_reg == TIMER_LAST;

    // one-second interval, restarted when the mode changes
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_reg <= '0;
        end else if (!auto_mode || mode_changed || timer_expire) begin
            timer_reg <= '0;
        end else if (mode_written_reg) begin
            timer_reg <= timer_reg + TIMER_W'(1);
        end
    end

    // manual copy on rising transfer request
    assign transfer = timer_expire || (!auto_mode && transfer_rise);

    logic [16:0] count_sum;
    logic overflow;
    assign count_sum = {1'b0, count_reg} + {15'h0000, increment};
    assign overflow = mode_written_reg && !transfer && count_sum[16];

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 16'h0000;
        end else if (!mode_written_reg) begin
            count_reg <= 16'h0000;
        end else if (transfer) begin
            // errors of the copy cycle start the next interval
            count_reg <= {14'h0000, increment};
        end else if (overflow) begin
            count_reg <= 16'hffff;
        end else begin
            count_reg <= count_sum[15:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            result_reg <= 16'h0000;
        end else if (transfer) begin
            result_reg <= count_reg;
        end
    end

    // ---------------- status flags ----------------
    logic [7:0] flag_set;
    always_comb begin
        flag_set = 8'h00;
        // each detected error sets its flag
        flag_set[line_error_pkg::BIT_PATTERN_ERROR] = pattern_error;
        flag_set[line_error_pkg::BIT_VIOLATION] = line_violation;
        flag_set[line_error_pkg::BIT_EXCESS_ZERO] = excess_zero_error;
        flag_set[line_error_pkg::BIT_TIMER] = timer_expire;
        flag_set[line_error_pkg::BIT_OVERFLOW] = overflow;
    end

    // read clears, a new event in the same cycle wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status_reg <= line_error_pkg::RESET_STATUS;
        end else if (read_status) begin
            status_reg <= flag_set;
        end else begin
            status_reg <= status_reg | flag_set;
        end
    end

    assign interrupt_request = |(status_reg & ~mask_reg);

    // ---------------- transmit insertion ----------------
    logic violation_pending_reg;
    logic [1:0] tx_pos_pipe_reg;
    logic [1:0] tx_neg_pipe_reg;
    logic three_ones;
    assign three_ones = tx_line.bit_en && (tx_line.pos | tx_line.neg)
        && (tx_pos_pipe_reg[0] | tx_neg_pipe_reg[0]) && (tx_pos_pipe_reg[1] | tx_neg_pipe_reg[1]);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            violation_pending_reg <= 1'b0;
        end else if (violation_insert_rise) begin
            violation_pending_reg <= 1'b1;
        end else if (violation_pending_reg && three_ones) begin
            violation_pending_reg <= 1'b0;
        end
    end

    // middle of three ones leaves with swapped polarity
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_pos_pipe_reg <= 2'h0;
            tx_neg_pipe_reg <= 2'h0;
        end else if (tx_line.bit_en) begin
            tx_pos_pipe_reg[0] <= tx_line.pos;
            tx_neg_pipe_reg[0] <= tx_line.neg;
            if (violation_pending_reg && three_ones) begin
                tx_pos_pipe_reg[1] <= tx_neg_pipe_reg[0];
                tx_neg_pipe_reg[1] <= tx_pos_pipe_reg[0];
            end else begin
                tx_pos_pipe_reg[1] <= tx_pos_pipe_reg[0];
                tx_neg_pipe_reg[1] <= tx_neg_pipe_reg[0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_line_out <= '0;
        end else begin
            tx_line_out.bit_en <= tx_line.bit_en;
            if (tx_line.bit_en) begin
                tx_line_out.pos <= tx_pos_pipe_reg[1];
                tx_line_out.neg <= tx_neg_pipe_reg[1];
            end
        end
    end

    logic logic_error_pending_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            logic_error_pending_reg <= 1'b0;
        end else if (logic_error_insert_rise) begin
            logic_error_pending_reg <= 1'b1;
        end else if (tx_pattern.bit_en && tx_pattern.active) begin
            logic_error_pending_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_pattern_out <= 1'b0;
        end else if (tx_pattern.bit_en) begin
            tx_pattern_out <= tx_pattern.data ^ (logic_error_pending_reg && tx_pattern.active);
        end
    end

endmodule // line_error_counter
`default_nettype wire

// ===== test/line_error_counter_properties.sv
`timescale 1ns/1ps
`default_nettype none
module line_error_counter_properties (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [1:0] coding_mode,
    input wire logic single_rail,
    input wire line_error_pkg::rail_pair_t rx_line,
    input wire line_error_pkg::rail_pair_t tx_line,
    input wire line_error_pkg::rail_pair_t tx_line_out,
    input wire line_error_pkg::pattern_bit_t tx_pattern,
    input wire logic tx_pattern_out,
    input wire logic violation_output_pin,
    input wire logic interrupt_request
);
    logic last_pos_reg;
    logic seen_reg;
    wire logic pulse = rx_line.bit_en && (rx_line.pos ^ rx_line.neg);
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last_pos_reg <= 1'b0;
            seen_reg <= 1'b0;
        end else if (pulse) begin
            last_pos_reg <= rx_line.pos;
            seen_reg <= 1'b1;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    AST_AMI_VIOLATION: assert property (
        pulse && seen_reg && rx_line.pos == last_pos_reg && coding_mode == 2'h0 && single_rail
        |=> violation_output_pin) else $error("ami violation missing on pin");
    AST_PIN_CAUSE: assert property (
        $rose(violation_output_pin) |-> $past(rx_line.bit_en) && $past(single_rail))
        else $error("violation pin rose outside a bit slot");
    AST_PIN_HOLD: assert property (
        violation_output_pin && !rx_line.bit_en |=> violation_output_pin)
        else $error("violation pin dropped inside its slot");
    AST_RDATA_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
        else $error("read data changed without a read");
    AST_UNMAPPED_ZERO: assert property (
        reg_rd && !(reg_addr inside {8'h10, 8'h12, 8'h17, 8'h18, 8'h19}) |=> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    AST_IRQ_FALL: assert property (
        $fell(interrupt_request) |-> $past(reg_rd && reg_addr == 8'h17) || $past(reg_wr && reg_addr == 8'h12))
        else $error("interrupt dropped without status read or mask write");
    AST_PATTERN_HOLD: assert property (!tx_pattern.bit_en |=> $stable(tx_pattern_out))
        else $error("pattern output changed outside a slot");
    AST_TX_SLOT: assert property (1'b1 |=> tx_line_out.bit_en == $past(tx_line.bit_en))
        else $error("transmit slot strobe not delayed by one cycle");
    COV_PIN: cover property ($rose(violation_output_pin));
    COV_IRQ: cover property ($rose(interrupt_request));
    COV_PAT: cover property (tx_pattern.bit_en ##1 $changed(tx_pattern_out));
endmodule // line_error_counter_properties
bind line_error_counter line_error_counter_properties checker_i (.clk, .rst_n, .reg_addr, .reg_wr, .reg_rd,
    .reg_rdata, .coding_mode, .single_rail, .rx_line, .tx_line, .tx_line_out, .tx_pattern, .tx_pattern_out,
    .violation_output_pin, .interrupt_request);
`default_nettype wire

// ===== test/line_partner.sv
`timescale 1ns/1ps
`default_nettype none
module line_partner (
    input wire logic clk,
    output line_error_pkg::rail_pair_t rx_line,
    output line_error_pkg::rail_pair_t tx_line,
    output line_error_pkg::pattern_bit_t tx_pattern,
    output logic pattern_error,
    input wire line_error_pkg::rail_pair_t tx_line_out,
    input wire logic tx_pattern_out
);
    int pos_seen = 0;
    int neg_seen = 0;
    int pat_ones = 0;
    initial begin
        rx_line = '0;
        tx_line = '0;
        tx_pattern = '0;
        pattern_error = 1'b0;
    end
    always @(posedge clk) begin
        if (tx_line_out.bit_en) begin
            pos_seen += int'(tx_line_out.pos);
            neg_seen += int'(tx_line_out.neg);
        end
    end
    // one receive slot, rails inverted between slots
    task automatic slot_rx(input logic p, input logic n);
        @(posedge clk); #1;
        rx_line = '{1'b1, p, n};
        @(posedge clk); #1;
        rx_line = '{1'b0, !p, !n};
    endtask
    task automatic slot_tx(input logic p, input logic n);
        @(posedge clk); #1;
        tx_line = '{1'b1, p, n};
        @(posedge clk); #1;
        tx_line = '{1'b0, !p, !n};
    endtask
    // counts pattern ones seen after each slot
    task automatic slot_pat(input logic act, input logic d);
        @(posedge clk); #1;
        tx_pattern = '{1'b1, act, d};
        @(posedge clk); #1;
        tx_pattern = '{1'b0, act, !d};
        pat_ones += int'(tx_pattern_out);
    endtask
    // pattern errors on n consecutive cycles
    task automatic perr(input int n);
        @(posedge clk); #1;
        pattern_error = 1'b1;
        repeat (n) @(posedge clk);
        #1;
        pattern_error = 1'b0;
    endtask
endmodule // line_partner
`default_nettype wire

// ===== test/line_error_counter_tb.sv
`timescale 1ns/1ps
`default_nettype none
module line_error_counter_tb;
    localparam longint TCYC = 2000;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic [1:0] coding_mode = 2'h0;
    logic single_rail = 1'b1;
    line_error_pkg::rail_pair_t rx_line, tx_line, tx_line_out;
    line_error_pkg::pattern_bit_t tx_pattern;
    logic pattern_error, tx_pattern_out, violation_output_pin, interrupt_request;
    logic last_pos = 1'b0;
    logic [7:0] dummy;
    int lim [4] = '{15, 80, 3, 7};
    int fail_count = 0;
    int n_compared = 0;
    always #2.5 clk = ~clk;
    line_error_counter #(.TIMER_CYCLES(TCYC)) dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .coding_mode, .single_rail, .rx_line, .pattern_error, .tx_line, .tx_line_out, .tx_pattern,
        .tx_pattern_out, .violation_output_pin, .interrupt_request);
    line_partner far_end (.clk, .rx_line, .tx_line, .tx_pattern, .pattern_error, .tx_line_out, .tx_pattern_out);
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #1;
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk); #1;
        reg_wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk); #1;
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk); #1;
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
    task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        check(what, {8'h00, d}, {8'h00, exp});
    endtask
    task automatic mark(input logic same);
        logic p;
        p = same ? last_pos : !last_pos;
        far_end.slot_rx(p, !p);
        last_pos = p;
    endtask
    task automatic zeros(input int n);
        repeat (n) far_end.slot_rx(1'b0, 1'b0);
    endtask
    task automatic count_is(input logic [7:0] ctl, input logic [15:0] exp);
        logic [7:0] lo, hi;
        wr(8'h10, ctl | 8'h02);
        rd(8'h18, lo);
        rd(8'h19, hi);
        check("count", {hi, lo}, exp);
        wr(8'h10, ctl);
    endtask
    task automatic wait_irq();
        int w;
        w = 0;
        while (interrupt_request !== 1'b1 && w < 3 * TCYC) begin
            @(posedge clk); #1;
            w++;
        end
        check("irq", {15'h0, interrupt_request}, 16'h1);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        rdc("control", 8'h10, 8'h00);
        rdc("mask", 8'h12, 8'hff);
        rdc("status", 8'h17, 8'h00);
        wr(8'h18, 8'h5a);
        rdc("count low", 8'h18, 8'h00);
        rdc("unmapped", 8'h11, 8'h00);
        $display("test reset done");
        wr(8'h12, 8'h00);
        mark(1'b0);
        for (int s = 0; s < 4; s++) begin
            wr(8'h10, 8'(s << 2));
            mark(1'b0);
            mark(1'b1);
            check("pin", {15'h0, violation_output_pin}, 16'h1);
            zeros(16);
            mark(1'b0);
            far_end.perr(1);
            count_is(8'(s << 2), (s == 3) ? 16'h2 : 16'h1);
        end
        check("irq", {15'h0, interrupt_request}, 16'h1);
        rdc("status", 8'h17, 8'h07);
        check("irq cleared", {15'h0, interrupt_request}, 16'h0);
        wr(8'h12, 8'hff);
        single_rail = 1'b0;
        mark(1'b1);
        check("pin off", {15'h0, violation_output_pin}, 16'h0);
        single_rail = 1'b1;
        check("irq masked", {15'h0, interrupt_request}, 16'h0);
        rdc("status", 8'h17, 8'h02);
        count_is(8'h0c, 16'h1);
        $display("test select done");
        for (int k = 0; k < 4; k++) begin
            coding_mode = (k < 2) ? 2'h0 : 2'(k - 1);
            wr(8'h10, (k == 1) ? 8'h18 : 8'h08);
            mark(1'b0);
            zeros(lim[k]);
            mark(1'b0);
            zeros(lim[k] + 1);
            mark(1'b0);
            count_is((k == 1) ? 8'h18 : 8'h08, 16'h1);
        end
        wr(8'h10, 8'h04);
        mark(1'b0);
        zeros(3);
        mark(1'b1);
        mark(1'b1);
        count_is(8'h04, 16'h1);
        $display("test zero limits done");
        for (int a = 0; a < 2; a++) begin
            if (a == 1) begin
                wr(8'h10, 8'h68);
            end
            far_end.pos_seen = 0;
            far_end.neg_seen = 0;
            far_end.pat_ones = 0;
            repeat (3) far_end.slot_tx(1'b0, 1'b0);
            repeat (3) begin
                far_end.slot_tx(1'b1, 1'b0);
                far_end.slot_tx(1'b0, 1'b1);
            end
            repeat (4) far_end.slot_tx(1'b0, 1'b0);
            check("tx marks", {8'(far_end.pos_seen), 8'(far_end.neg_seen)}, {8'(3 + a), 8'(3 - a)});
            repeat (8) far_end.slot_pat(1'b1, 1'b0);
            check("pattern flips", 16'(far_end.pat_ones), 16'(a));
        end
        $display("test insertion done");
        coding_mode = 2'h0;
        wr(8'h12, 8'h00);
        wr(8'h10, 8'h05);
        repeat (3) mark(1'b1);
        rd(8'h17, dummy);
        for (int r = 0; r < 2; r++) begin
            wait_irq();
            rdc("status", 8'h17, 8'h08);
            rdc("count low", 8'(3 - 3 * r) == 8'h00 ? 8'h18 : 8'h18, 8'(3 - 3 * r));
            rdc("count high", 8'h19, 8'h00);
            rdc("status", 8'h17, 8'h00);
        end
        $display("test auto report done");
        wr(8'h10, 8'h00);
        rd(8'h17, dummy);
        far_end.perr(65536);
        count_is(8'h00, 16'hffff);
        rdc("status", 8'h17, 8'h11);
        $display("test overflow done");
        test_done();
    end
    initial begin
        #450000;
        fail_count++;
        $display("watchdog expired");
        test_done();
    end
endmodule // line_error_counter_tb
`default_nettype wire
